// ===== common/cpwm_pkg.sv
// constants for the complementary pwm output stage
package cpwm_pkg;

    // ------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_TIMER_CONTROL_ONE   = 8'h00;
    localparam logic [7:0] ADDR_INTERRUPT_ENABLE    = 8'h04;
    localparam logic [7:0] ADDR_OUTPUT_ENABLE_POL   = 8'h08;
    localparam logic [7:0] ADDR_DEAD_TIME_BREAK     = 8'h0C;
    localparam logic [7:0] ADDR_RELOAD_VALUE        = 8'h10;
    localparam logic [7:0] ADDR_COMPARE_VALUE_CH1   = 8'h14;
    localparam logic [7:0] ADDR_COMPARE_VALUE_CH2   = 8'h18;
    localparam logic [7:0] ADDR_REFERENCE_MODE      = 8'h1C;
    localparam logic [7:0] ADDR_IDLE_LEVEL          = 8'h20;
    localparam logic [7:0] ADDR_COUNTER_STATUS      = 8'h24;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int TC_DIR_BIT       = 4;
    localparam int TC_CMS_LSB       = 5;
    localparam int TC_CKD_LSB       = 8;
    localparam int IE_UPDATE_BIT    = 0;
    localparam int IE_CC1_BIT       = 1;
    localparam int IE_CC2_BIT       = 2;
    localparam int OE_CH1_MAIN_EN   = 0;
    localparam int OE_CH1_MAIN_POL  = 1;
    localparam int OE_CH1_COMP_EN   = 2;
    localparam int OE_CH1_COMP_POL  = 3;
    localparam int OE_CH2_MAIN_EN   = 4;
    localparam int OE_CH2_MAIN_POL  = 5;
    localparam int DT_GATE_BIT      = 15;
    localparam int RM_CH1_LSB       = 0;
    localparam int RM_CH2_LSB       = 4;
    localparam int IDLE_CH1_MAIN    = 0;
    localparam int IDLE_CH1_COMP    = 1;
    localparam int IDLE_CH2_MAIN    = 2;

    // ------------------------------------------------------------
    // widths and reset values
    // ------------------------------------------------------------
    localparam int CNT_W  = 16;
    localparam int DT_W   = 10;
    localparam logic [15:0] RESET_RELOAD  = 16'hFFFF;
    localparam logic [15:0] RESET_CTRL    = 16'h0000;
    localparam logic [15:0] RESET_GATE    = 16'h8000;

    // ------------------------------------------------------------
    // variants, reference modes, bus states
    // ------------------------------------------------------------
    localparam logic [1:0] VAR_TWO_CH_COMP = 2'h0;
    localparam logic [1:0] VAR_ONE_CH_COMP = 2'h1;
    localparam logic [1:0] VAR_ONE_CH_GP   = 2'h2;

    typedef enum logic [2:0] {
        RM_FROZEN     = 3'h0,
        RM_MATCH_HIGH = 3'h1,
        RM_MATCH_LOW  = 3'h2,
        RM_TOGGLE     = 3'h3,
        RM_FORCE_LOW  = 3'h4,
        RM_FORCE_HIGH = 3'h5,
        RM_PWM_ONE    = 3'h6,
        RM_PWM_TWO    = 3'h7
    } cpwm_mode_e;

    typedef enum logic [2:0] {
        BUS_IDLE  = 3'b001,
        BUS_RLOAD = 3'b010,
        BUS_RDONE = 3'b100
    } cpwm_bus_e;

    // dead-time tick divide codes
    localparam logic [1:0] CKD_DIV1 = 2'h0;
    localparam logic [1:0] CKD_DIV2 = 2'h1;
    localparam logic [1:0] DIV_MAX2 = 2'h1;
    localparam logic [1:0] DIV_MAX4 = 2'h3;

endpackage

// ===== verilog/cpwm_deadtime.sv
// dead-time insertion for one complementary pair
`timescale 1ns/1ps
`default_nettype none
module cpwm_deadtime
(
    input  wire logic                     clk_i,
    input  wire logic                     rstn_i,
    input  wire logic                     ref_i,
    input  wire logic                     tick_i,
    input  wire logic [cpwm_pkg::DT_W-1:0] dt_ticks_i,
    output logic                          main_o,
    output logic                          comp_o
);

    logic                      ref_q_r;
    logic [cpwm_pkg::DT_W-1:0] cnt_r;
    logic                      settled;

    assign settled = (cnt_r == '0) && (ref_i == ref_q_r);

    always_ff @(posedge clk_i)
    begin
        if (!rstn_i)
            ref_q_r <= 1'b0;
        else
            ref_q_r <= ref_i;
    end

    always_ff @(posedge clk_i)
    begin
        if (!rstn_i)
            cnt_r <= '0;
        else if (ref_i != ref_q_r)
            // spare tick covers the free-running divider phase
            cnt_r <= dt_ticks_i + 1'b1;
        else if (tick_i && cnt_r != '0)
            cnt_r <= cnt_r - 1'b1;
    end

    // both outputs low while the dead time runs
    always_ff @(posedge clk_i)
    begin
        if (!rstn_i)
        begin
            main_o <= 1'b0;
            comp_o <= 1'b0;
        end
        else
        begin
            main_o <= settled & ref_q_r;
            comp_o <= settled & ~ref_q_r;
        end
    end

endmodule
`default_nettype wire

// ===== verilog/cpwm_top.sv
// complementary pwm output stage with ahb-lite register slave
// Function
// - 16-bit up-counting edge-aligned counter
// - polarity bit 1 inverts each output
// - enable bit selects reference or idle level
// - channel 1 single-enable output table
// - both enables give complementary pair
// - with both enables, every rising edge delayed by dead time
// - code 0xx gives code times tick
// - code 10x gives (64+low6) times two
// - codes 110/111 give (32+low5) times 8/16
// - tick is 1, 2 or 4 clocks
// - channel 2 single polarity output only
// - two-channel variant drives full output set
// - one-channel complementary drops channel 2
// - general purpose variant single output only
// - general purpose ignores complement polarity
// - inactive output takes its idle level
// - compare, reload, modes load at update
// - enable and polarity act at once
// - flags are single-cycle pulses
//
// The AHB-Lite interface to the registers and the placing of the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
module cpwm_top
#(
    parameter logic [1:0] variant_p = cpwm_pkg::VAR_TWO_CH_COMP
)
(
    input  wire logic        clk_i,
    input  wire logic        rstn_i,
    input  wire logic        hsel_i,
    input  wire logic [31:0] haddr_i,
    input  wire logic [1:0]  htrans_i,
    input  wire logic        hwrite_i,
    input  wire logic [2:0]  hsize_i,
    input  wire logic [31:0] hwdata_i,
    input  wire logic        hready_i,
    output logic             hreadyout_o,
    output logic [31:0]      hrdata_o,
    output logic             hresp_o,
    input  wire logic        sync_i,
    output logic             ch1_main_output_o,
    output logic             ch1_comp_output_o,
    output logic             ch2_main_output_o,
    output logic             compare_flag_ch1_o,
    output logic             compare_flag_ch2_o,
    output logic             update_flag_o
);

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [15:0] timer_control_one_r;
    logic [15:0] interrupt_enable_control_r;
    logic [15:0] output_enable_polarity_control_r;
    logic [15:0] dead_time_break_control_r;
    logic [15:0] reload_value_r;
    logic [15:0] compare_value_ch1_r;
    logic [15:0] compare_value_ch2_r;
    logic [15:0] reference_mode_r;
    logic [15:0] idle_level_r;

    logic [15:0] reload_sh_r;
    logic [15:0] cmp1_sh_r;
    logic [15:0] cmp2_sh_r;
    logic [2:0]  mode1_sh_r;
    logic [2:0]  mode2_sh_r;

    cpwm_pkg::cpwm_bus_e bus_st_r;
    logic        wr_pend_r;
    logic [7:0]  addr_r;
    logic        addr_ok_r;
    logic        accept;
    logic [31:0] rd_mux;

    // ------------------------------------------------------------
    // ahb-lite slave
    // ------------------------------------------------------------
    assign accept      = hsel_i && htrans_i[1] && hready_i;
    assign hreadyout_o = (bus_st_r != cpwm_pkg::BUS_RLOAD);
    assign hresp_o     = 1'b0;

    always_ff @(posedge clk_i)
    begin
        if (!rstn_i)
        begin
            addr_r    <= 8'h00;
            addr_ok_r <= 1'b0;
            wr_pend_r <= 1'b0;
        end
        else if (hready_i)
        begin
            addr_r    <= haddr_i[7:0];
            addr_ok_r <= (haddr_i[31:8] == 24'h000000);
            wr_pend_r <= accept && hwrite_i;
        end
    end

    // reads take one wait state so a write just before is seen
    always_ff @(posedge clk_i)
    begin
        if (!rstn_i)
            bus_st_r <= cpwm_pkg::BUS_IDLE;
        else
        begin
            unique case (bus_st_r)
                cpwm_pkg::BUS_IDLE,
                cpwm_pkg::BUS_RDONE:
                    if (accept && !hwrite_i)
                        bus_st_r <= cpwm_pkg::BUS_RLOAD;
                    else
                        bus_st_r <= cpwm_pkg::BUS_IDLE;
                cpwm_pkg::BUS_RLOAD:
                    bus_st_r <= cpwm_pkg::BUS_RDONE;
                default:
                    bus_st_r <= cpwm_pkg::BUS_IDLE;
            endcase
        end
    end

    logic [15:0] cnt_r;

    always_comb
    begin
        rd_mux = 32'h00000000;
        if (addr_ok_r)
        begin
            unique case (addr_r)
                cpwm_pkg::ADDR_TIMER_CONTROL_ONE:
                    rd_mux[15:0] = timer_control_one_r;
                cpwm_pkg::ADDR_INTERRUPT_ENABLE:
                    rd_mux[15:0] = interrupt_enable_control_r;
                cpwm_pkg::ADDR_OUTPUT_ENABLE_POL:
                    rd_mux[15:0] = output_enable_polarity_control_r;
                cpwm_pkg::ADDR_DEAD_TIME_BREAK:
                    rd_mux[15:0] = dead_time_break_control_r;
                cpwm_pkg::ADDR_RELOAD_VALUE:
                    rd_mux[15:0] = reload_value_r;
                cpwm_pkg::ADDR_COMPARE_VALUE_CH1:
                    rd_mux[15:0] = compare_value_ch1_r;
                cpwm_pkg::ADDR_COMPARE_VALUE_CH2:
                    rd_mux[15:0] = compare_value_ch2_r;
                cpwm_pkg::ADDR_REFERENCE_MODE:
                    rd_mux[15:0] = reference_mode_r;
                cpwm_pkg::ADDR_IDLE_LEVEL:
                    rd_mux[15:0] = idle_level_r;
                cpwm_pkg::ADDR_COUNTER_STATUS:
                    rd_mux[15:0] = cnt_r;
                default:
                    rd_mux = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (!rstn_i)
            hrdata_o <= 32'h00000000;
        else if (bus_st_r == cpwm_pkg::BUS_RLOAD)
            hrdata_o <= rd_mux;
    end

    always_ff @(posedge clk_i)
    begin
        if (!rstn_i)
        begin
            timer_control_one_r              <= cpwm_pkg::RESET_CTRL;
            interrupt_enable_control_r       <= cpwm_pkg::RESET_CTRL;
            output_enable_polarity_control_r <= cpwm_pkg::RESET_CTRL;
            dead_time_break_control_r        <= cpwm_pkg::RESET_GATE;
            reload_value_r                   <= cpwm_pkg::RESET_RELOAD;
            compare_value_ch1_r              <= cpwm_pkg::RESET_CTRL;
            compare_value_ch2_r              <= cpwm_pkg::RESET_CTRL;
            reference_mode_r                 <= cpwm_pkg::RESET_CTRL;
            idle_level_r                     <= cpwm_pkg::RESET_CTRL;
        end
        else if (wr_pend_r && addr_ok_r)
        begin
            unique case (addr_r)
                cpwm_pkg::ADDR_TIMER_CONTROL_ONE:
                    timer_control_one_r <= hwdata_i[15:0];
                cpwm_pkg::ADDR_INTERRUPT_ENABLE:
                    interrupt_enable_control_r <= hwdata_i[15:0];
                cpwm_pkg::ADDR_OUTPUT_ENABLE_POL:
                    output_enable_polarity_control_r <= hwdata_i[15:0];
                cpwm_pkg::ADDR_DEAD_TIME_BREAK:
                    dead_time_break_control_r <= hwdata_i[15:0];
                cpwm_pkg::ADDR_RELOAD_VALUE:
                    reload_value_r <= hwdata_i[15:0];
                cpwm_pkg::ADDR_COMPARE_VALUE_CH1:
                    compare_value_ch1_r <= hwdata_i[15:0];
                cpwm_pkg::ADDR_COMPARE_VALUE_CH2:
                    compare_value_ch2_r <= hwdata_i[15:0];
                cpwm_pkg::ADDR_REFERENCE_MODE:
                    reference_mode_r <= hwdata_i[15:0];
                cpwm_pkg::ADDR_IDLE_LEVEL:
                    idle_level_r <= hwdata_i[15:0];
                default:
                    idle_level_r <= idle_level_r;
            endcase
        end
    end

    // ------------------------------------------------------------
    // counter and preload
    // ------------------------------------------------------------
    logic sync_d_r;
    logic sync_rise;
    logic wrap;
    logic upd_evt;

    assign sync_rise = sync_i & ~sync_d_r;
    assign wrap      = (cnt_r == reload_sh_r);
    assign upd_evt   = sync_rise | wrap;

    always_ff @(posedge clk_i)
    begin
        if (!rstn_i)
            sync_d_r <= 1'b0;
        else
            sync_d_r <= sync_i;
    end

    always_ff @(posedge clk_i)
    begin
        if (!rstn_i)
            cnt_r <= 16'h0000;
        else if (upd_evt)
            cnt_r <= 16'h0000;
        else
            cnt_r <= cnt_r + 16'h0001;
    end

    always_ff @(posedge clk_i)
    begin
        if (!rstn_i)
        begin
            reload_sh_r <= cpwm_pkg::RESET_RELOAD;
            cmp1_sh_r   <= cpwm_pkg::RESET_CTRL;
            cmp2_sh_r   <= cpwm_pkg::RESET_CTRL;
            mode1_sh_r  <= 3'h0;
            mode2_sh_r  <= 3'h0;
        end
        else if (upd_evt)
        begin
            reload_sh_r <= reload_value_r;
            cmp1_sh_r   <= compare_value_ch1_r;
            cmp2_sh_r   <= compare_value_ch2_r;
            mode1_sh_r  <= reference_mode_r[cpwm_pkg::RM_CH1_LSB +: 3];
            mode2_sh_r  <= reference_mode_r[cpwm_pkg::RM_CH2_LSB +: 3];
        end
    end

    // ------------------------------------------------------------
    // reference waveforms
    // ------------------------------------------------------------
    logic ref1_r;
    logic ref2_r;
    logic match1;
    logic match2;

    assign match1 = (cnt_r == cmp1_sh_r);
    assign match2 = (cnt_r == cmp2_sh_r);

    function automatic logic ref_next(input logic [2:0] mode,
                                      input logic       cur,
                                      input logic       hit,
                                      input logic [15:0] cnt,
                                      input logic [15:0] cmp);
        logic r;
        r = cur;
        unique case (cpwm_pkg::cpwm_mode_e'(mode))
            cpwm_pkg::RM_FROZEN:     r = cur;
            cpwm_pkg::RM_MATCH_HIGH: r = hit ? 1'b1 : cur;
            cpwm_pkg::RM_MATCH_LOW:  r = hit ? 1'b0 : cur;
            cpwm_pkg::RM_TOGGLE:     r = hit ? ~cur : cur;
            cpwm_pkg::RM_FORCE_LOW:  r = 1'b0;
            cpwm_pkg::RM_FORCE_HIGH: r = 1'b1;
            cpwm_pkg::RM_PWM_ONE:    r = (cnt < cmp);
            cpwm_pkg::RM_PWM_TWO:    r = ~(cnt < cmp);
        endcase
        return r;
    endfunction

    always_ff @(posedge clk_i)
    begin
        if (!rstn_i)
        begin
            ref1_r <= 1'b0;
            ref2_r <= 1'b0;
        end
        else
        begin
            ref1_r <= ref_next(mode1_sh_r, ref1_r, match1, cnt_r, cmp1_sh_r);
            ref2_r <= ref_next(mode2_sh_r, ref2_r, match2, cnt_r, cmp2_sh_r);
        end
    end

    // ------------------------------------------------------------
    // dead-time tick and length
    // ------------------------------------------------------------
    logic [1:0]              dead_time_clock_divide;
    logic [1:0]              div_r;
    logic [1:0]              div_max;
    logic                    tick;
    logic [7:0]              dtg;
    logic [cpwm_pkg::DT_W-1:0] dt_ticks;

    assign dead_time_clock_divide = timer_control_one_r[cpwm_pkg::TC_CKD_LSB +: 2];
    assign dtg = dead_time_break_control_r[7:0];

    // tick of 1, 2 or 4 clocks
    always_comb
    begin
        if (dead_time_clock_divide == cpwm_pkg::CKD_DIV1)
            div_max = 2'h0;
        else if (dead_time_clock_divide == cpwm_pkg::CKD_DIV2)
            div_max = cpwm_pkg::DIV_MAX2;
        else
            div_max = cpwm_pkg::DIV_MAX4;
    end

    assign tick = (div_r >= div_max);

    always_ff @(posedge clk_i)
    begin
        if (!rstn_i)
            div_r <= 2'h0;
        else if (tick)
            div_r <= 2'h0;
        else
            div_r <= div_r + 2'h1;
    end

    always_comb
    begin
        if (!dtg[7])
            dt_ticks = {2'h0, dtg};
        else if (!dtg[6])
            dt_ticks = {1'b0, 2'h1, dtg[5:0], 1'b0};
        // 110 times 8, 111 times 16
        else if (!dtg[5])
            dt_ticks = {2'h0, 1'b1, dtg[4:0], 2'h0} << 1;
        else
            dt_ticks = {1'b0, 1'b1, dtg[4:0], 3'h0} << 1;
    end

    logic dt_main;
    logic dt_comp;

    cpwm_deadtime u_deadtime
    (
        .clk_i      (clk_i),
        .rstn_i     (rstn_i),
        .ref_i      (ref1_r),
        .tick_i     (tick),
        .dt_ticks_i (dt_ticks),
        .main_o     (dt_main),
        .comp_o     (dt_comp)
    );

    // ------------------------------------------------------------
    // output stage
    // ------------------------------------------------------------
    logic [15:0] oe;
    logic        m1_en;
    logic        c1_en;
    logic        m1_nxt;
    logic        c1_nxt;
    logic        m2_nxt;

    assign oe    = output_enable_polarity_control_r;
    assign m1_en = oe[cpwm_pkg::OE_CH1_MAIN_EN];
    assign c1_en = oe[cpwm_pkg::OE_CH1_COMP_EN] &&
                   (variant_p != cpwm_pkg::VAR_ONE_CH_GP);

    always_comb
    begin
        m1_nxt = idle_level_r[cpwm_pkg::IDLE_CH1_MAIN];
        c1_nxt = idle_level_r[cpwm_pkg::IDLE_CH1_COMP];
        if (m1_en && c1_en)
        begin
            m1_nxt = dt_main ^ oe[cpwm_pkg::OE_CH1_MAIN_POL];
            c1_nxt = dt_comp ^ oe[cpwm_pkg::OE_CH1_COMP_POL];
        end
        else if (m1_en)
            m1_nxt = ref1_r ^ oe[cpwm_pkg::OE_CH1_MAIN_POL];
        else if (c1_en)
            c1_nxt = ref1_r ^ oe[cpwm_pkg::OE_CH1_COMP_POL];
        if (variant_p == cpwm_pkg::VAR_ONE_CH_GP)
            c1_nxt = 1'b0;
        if (oe[cpwm_pkg::OE_CH2_MAIN_EN])
            m2_nxt = ref2_r ^ oe[cpwm_pkg::OE_CH2_MAIN_POL];
        else
            m2_nxt = idle_level_r[cpwm_pkg::IDLE_CH2_MAIN];
        if (variant_p != cpwm_pkg::VAR_TWO_CH_COMP)
            m2_nxt = 1'b0;
    end

    // full output set in two-channel variant
    always_ff @(posedge clk_i)
    begin
        if (!rstn_i)
        begin
            ch1_main_output_o <= 1'b0;
            ch1_comp_output_o <= 1'b0;
            ch2_main_output_o <= 1'b0;
        end
        else
        begin
            ch1_main_output_o <= m1_nxt;
            ch1_comp_output_o <= c1_nxt;
            ch2_main_output_o <= m2_nxt;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (!rstn_i)
        begin
            compare_flag_ch1_o <= 1'b0;
            compare_flag_ch2_o <= 1'b0;
            update_flag_o      <= 1'b0;
        end
        else
        begin
            compare_flag_ch1_o <= match1 &&
                interrupt_enable_control_r[cpwm_pkg::IE_CC1_BIT];
            compare_flag_ch2_o <= match2 &&
                interrupt_enable_control_r[cpwm_pkg::IE_CC2_BIT] &&
                (variant_p == cpwm_pkg::VAR_TWO_CH_COMP);
            update_flag_o      <= upd_evt &&
                interrupt_enable_control_r[cpwm_pkg::IE_UPDATE_BIT];
        end
    end

endmodule
`default_nettype wire

// ===== tb/cpwm_gate_model.sv
// gate drive stand-in that measures the off gap of the channel 1 pair
`timescale 1ns/1ps
`default_nettype none
module cpwm_gate_model
(
    input  wire logic   clk_i,
    input  wire logic   hi_i,
    input  wire logic   lo_i,
    output logic [15:0] gap_o,
    output logic        shoot_o
);
    logic [15:0] run_r = 16'h0000;
    logic [15:0] gap_r = 16'h0000;
    logic        shoot_r = 1'b0;
    assign gap_o = gap_r;
    assign shoot_o = shoot_r;
    always @(posedge clk_i)
    begin
        if (hi_i || lo_i)
            run_r <= 16'h0000;
        else
            run_r <= run_r + 16'h0001;
        if ((hi_i || lo_i) && run_r != 16'h0000)
            gap_r <= run_r;
        // both switches on at once would short the leg
        if (hi_i === 1'b1 && lo_i === 1'b1)
            shoot_r <= 1'b1;
    end
endmodule
`default_nettype wire

// ===== tb/cpwm_top_properties.sv
// port assertions for the pwm output stage
`timescale 1ns/1ps
`default_nettype none
module cpwm_top_properties
(
    input wire logic        clk_i,
    input wire logic        rstn_i,
    input wire logic        hsel_i,
    input wire logic [1:0]  htrans_i,
    input wire logic        hwrite_i,
    input wire logic        hready_i,
    input wire logic        hreadyout_o,
    input wire logic [31:0] hrdata_o,
    input wire logic        hresp_o,
    input wire logic        compare_flag_ch1_o,
    input wire logic        compare_flag_ch2_o,
    input wire logic        update_flag_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rstn_i);
    sequence s_take;
        hsel_i && htrans_i[1] && hready_i;
    endsequence
    sequence s_wait;
        !hreadyout_o ##1 hreadyout_o;
    endsequence
    a_read_wait:
        assert property (s_take ##0 !hwrite_i |=> s_wait)
        else $error("read data phase not one wait state");
    a_write_nowait:
        assert property (s_take ##0 hwrite_i |=> hreadyout_o)
        else $error("write data phase stalled");
    a_resp_okay:
        assert property (hresp_o == 1'b0)
        else $error("response not okay");
    a_rdata_upper:
        assert property (hrdata_o[31:16] == 16'h0000)
        else $error("read data upper half not zero");
    a_rdata_hold:
        assert property ($changed(hrdata_o) |->
            !$past(hreadyout_o) || !$past(rstn_i))
        else $error("read data changed outside a read");
    a_flag1_pulse:
        assert property (compare_flag_ch1_o |=> !compare_flag_ch1_o)
        else $error("compare flag one longer than a cycle");
    a_flag2_pulse:
        assert property (compare_flag_ch2_o |=> !compare_flag_ch2_o)
        else $error("compare flag two longer than a cycle");
    a_upd_pulse:
        assert property (update_flag_o |=> !update_flag_o)
        else $error("update flag longer than a cycle");
endmodule
bind cpwm_top cpwm_top_properties u_props (.clk_i, .rstn_i, .hsel_i,
    .htrans_i, .hwrite_i, .hready_i, .hreadyout_o, .hrdata_o, .hresp_o,
    .compare_flag_ch1_o, .compare_flag_ch2_o, .update_flag_o);
`default_nettype wire

// ===== tb/cpwm_top_tb.sv
// self-checking bench for the pwm output stage
`timescale 1ns/1ps
`default_nettype none
module cpwm_top_tb;
    logic        clk_i = 1'b0;
    logic        rstn_i = 1'b0;
    logic        hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic        sync = 1'b0;
    logic        rd_ph = 1'b0;
    logic        rdy_n = 1'b0;
    logic        hrdy, m, c, c2, f1, f2, upd, hresp, shoot;
    logic [31:0] hrdata;
    logic [15:0] gap, r;
    logic [31:0] expq[$];
    logic [5:0]  oe [4] = '{6'h11, 6'h04, 6'h33, 6'h0C};
    int          ex [4][3] = '{'{5,0,8}, '{0,5,0}, '{15,0,12}, '{0,15,0}};
    logic [7:0]  dcode [4] = '{8'h05, 8'h45, 8'hC2, 8'hE1};
    logic [1:0]  dkd [4] = '{2'h0, 2'h1, 2'h2, 2'h0};
    int          error_cnt = 0;
    int          total_checks = 0;
    int          hm, hc, h2, hf, sp, k, lo;
    cpwm_top u_dut (.clk_i(clk_i), .rstn_i(rstn_i), .hsel_i(hsel),
        .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
        .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hrdy),
        .hreadyout_o(hrdy), .hrdata_o(hrdata), .hresp_o(hresp),
        .sync_i(sync), .ch1_main_output_o(m), .ch1_comp_output_o(c),
        .ch2_main_output_o(c2), .compare_flag_ch1_o(f1),
        .compare_flag_ch2_o(f2), .update_flag_o(upd));
    cpwm_gate_model u_gate (.clk_i(clk_i), .hi_i(m), .lo_i(c),
        .gap_o(gap), .shoot_o(shoot));
    initial forever #20 clk_i = ~clk_i;
    always @(negedge clk_i) rdy_n <= hrdy;
    // ------------------------------------------------------------
    // checking
    // ------------------------------------------------------------
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("[FAIL] %0t got %0h exp %0h", $time, got, exp);
        end
    endtask
    always @(negedge clk_i)
        if (rd_ph && hrdy)
            check(hrdata, expq.pop_front());
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // ------------------------------------------------------------
    // bus and measurement tasks
    // ------------------------------------------------------------
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [15:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h000000, a};
        do @(posedge clk_i); while (!rdy_n);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {16'h0000, d};
        rd_ph <= !w;
        do @(posedge clk_i); while (!rdy_n);
        rd_ph <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        expq.push_back(e);
        bus(1'b0, a, 16'h0000);
    endtask
    task automatic meas();
        hm = 0;
        hc = 0;
        h2 = 0;
        hf = 0;
        sp = 0;
        do @(negedge clk_i); while (!upd);
        do
        begin
            @(negedge clk_i);
            sp++;
            hm += m;
            hc += c;
            h2 += c2;
            hf += f1 + f2;
        end while (!upd);
        @(posedge clk_i);
    endtask
    function automatic int dtime(input logic [7:0] d, input logic [1:0] q);
        int t;
        if (!d[7]) t = d;
        else if (!d[6]) t = (64 + d[5:0]) * 2;
        else t = (32 + d[4:0]) * (d[5] ? 16 : 8);
        return t << q;
    endfunction
    initial
    begin
        #2400000;
        error_cnt++;
        end_of_test();
    end
    initial
    begin
        void'($urandom(32'h57FAEDB9));
        repeat (8) @(posedge clk_i);
        rstn_i <= 1'b1;
        @(posedge clk_i);
        rd(cpwm_pkg::ADDR_RELOAD_VALUE, 32'h0000FFFF);
        rd(cpwm_pkg::ADDR_DEAD_TIME_BREAK, 32'h00008000);
        rd(8'h28, 32'h00000000);
        r = 16'($urandom);
        bus(1'b1, cpwm_pkg::ADDR_COMPARE_VALUE_CH2, r);
        rd(cpwm_pkg::ADDR_COMPARE_VALUE_CH2, {16'h0000, r});
        $display("registers done");
        bus(1'b1, cpwm_pkg::ADDR_TIMER_CONTROL_ONE, 16'h0000);
        bus(1'b1, cpwm_pkg::ADDR_INTERRUPT_ENABLE, 16'h0007);
        bus(1'b1, cpwm_pkg::ADDR_REFERENCE_MODE, 16'h0066);
        bus(1'b1, cpwm_pkg::ADDR_RELOAD_VALUE, 16'h0013);
        bus(1'b1, cpwm_pkg::ADDR_COMPARE_VALUE_CH1, 16'h0005);
        bus(1'b1, cpwm_pkg::ADDR_COMPARE_VALUE_CH2, 16'h0008);
        sync <= 1'b1;
        k = 0;
        do
        begin
            @(negedge clk_i);
            k++;
        end while (!upd && k < 9);
        check(k <= 4, 1'b1);
        @(posedge clk_i);
        sync <= 1'b0;
        foreach (oe[i])
        begin
            bus(1'b1, cpwm_pkg::ADDR_OUTPUT_ENABLE_POL, {10'h000, oe[i]});
            repeat (2) meas();
            check(sp, 20);
            check(hm, ex[i][0]);
            check(hc, ex[i][1]);
            check(h2, ex[i][2]);
            check(hf, 2);
        end
        bus(1'b1, cpwm_pkg::ADDR_IDLE_LEVEL, 16'h0005);
        bus(1'b1, cpwm_pkg::ADDR_OUTPUT_ENABLE_POL, 16'h0000);
        repeat (2) @(posedge clk_i);
        @(negedge clk_i);
        check({m, c, c2}, 3'h5);
        $display("output stage done");
        bus(1'b1, cpwm_pkg::ADDR_IDLE_LEVEL, 16'h0000);
        bus(1'b1, cpwm_pkg::ADDR_RELOAD_VALUE, 16'h0BB7);
        bus(1'b1, cpwm_pkg::ADDR_COMPARE_VALUE_CH1, 16'h05DC);
        bus(1'b1, cpwm_pkg::ADDR_OUTPUT_ENABLE_POL, 16'h0005);
        foreach (dcode[i])
        begin
            bus(1'b1, cpwm_pkg::ADDR_TIMER_CONTROL_ONE, {6'h00, dkd[i], 8'h00});
            bus(1'b1, cpwm_pkg::ADDR_DEAD_TIME_BREAK, {8'h80, dcode[i]});
            meas();
            lo = dtime(dcode[i], dkd[i]);
            check(gap >= lo && gap <= lo + (1 << dkd[i]) + 2, 1'b1);
        end
        check(shoot, 1'b0);
        $display("dead time done");
        end_of_test();
    end
endmodule
`default_nettype wire
